// *** design/bcs_pkg.sv ***
// Package for the battery charge-state control block: constants, types, state encoding
package bcs_pkg;

    // Clock rate and time base
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned TICK_MS        = 1;
    localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
    // Relax interval after total time-out in fast-charge
    localparam int unsigned RELAX_MS       = 32;
    localparam int unsigned RELAX_TICKS    = RELAX_MS / TICK_MS;
    // Safety timer periods in minutes
    localparam int unsigned PRE_MIN_0      = 40;
    localparam int unsigned PRE_MIN_1      = 60;
    localparam int unsigned PRE_MIN_2      = 80;
    localparam int unsigned TOT_MIN_0      = 3 * 60;
    localparam int unsigned TOT_MIN_1      = 4 * 60;
    localparam int unsigned TOT_MIN_2      = 5 * 60;
    localparam int unsigned MS_PER_MIN     = 60_000;

    // Current settings in mA for USB mode
    localparam logic [9:0] USB_HI_MA       = 10'd450;
    localparam logic [9:0] USB_LO_MA       = 10'd90;
    localparam logic [9:0] USB_PRE_MA      = 10'd45;
    localparam logic [9:0] USB_IN_HI_MA    = 10'd450;
    localparam logic [9:0] USB_IN_LO_MA    = 10'd100;
    // Divisors in AC mode
    localparam int unsigned AC_LOW_DIV     = 5;
    localparam int unsigned PRE_DIV        = 10;

    // Charge-state code field values
    localparam logic [1:0] CODE_PRE        = 2'h3;
    localparam logic [1:0] CODE_FAST       = 2'h1;
    localparam logic [1:0] CODE_EOC        = 2'h2;
    localparam logic [1:0] CODE_IDLE       = 2'h0;

    // Timer select code that disables a timer
    localparam logic [1:0] TIMER_OFF       = 2'h3;

    // Register bus map and bit positions
    localparam logic [3:0] ADDR_CTRL       = 4'h0;
    localparam logic [3:0] ADDR_STATUS     = 4'h1;
    localparam int unsigned CTRL_HOLD      = 0;
    localparam int unsigned CTRL_IN_CON    = 1;
    localparam int unsigned CTRL_IN_DIS    = 2;
    localparam int unsigned CTRL_EOC_IN    = 3;
    localparam int unsigned CTRL_EOC_OUT   = 4;
    localparam int unsigned CTRL_PRE_LSB   = 5;
    localparam int unsigned CTRL_TOT_LSB   = 7;
    localparam int unsigned ST_IN_FLAG     = 0;
    localparam int unsigned ST_IN_VALID    = 1;
    localparam int unsigned ST_AC_SEL      = 2;
    localparam int unsigned ST_CHG_FLAG    = 3;
    localparam int unsigned ST_EOC         = 4;
    localparam int unsigned ST_CODE_LSB    = 5;
    localparam logic [8:0]  CTRL_RESET     = 9'h000;

    typedef enum logic [2:0] {
        BCS_SUSPEND,
        BCS_PRECOND,
        BCS_FAST,
        BCS_TOPOFF,
        BCS_EOC,
        BCS_FAULT
    } bcs_state_t;

    // Analog comparator results
    typedef struct packed {
        logic ac_select_input;
        logic charge_level_input;
        logic input_valid;
        logic battery_present;
        logic above_precond;
        logic at_termination;
        logic below_recharge;
        logic current_at_eoc;
        logic current_reduced;
    } bcs_sense_t;

    // Power stage commands
    typedef struct packed {
        logic       charge_en;
        logic       cv_mode;
        logic [9:0] current_ma;
        logic [9:0] input_limit_ma;
        logic       use_current_set_pin;
        logic [3:0] current_set_pin_div;
    } bcs_drive_t;

endpackage : bcs_pkg

// *** design/bcs_charge_ctrl.sv ***
// Charge-state machine, current mode select, safety timers and flag registers
`timescale 1ns/100ps
`default_nettype none

module bcs_charge_ctrl #(
    parameter int unsigned TICK_CYCLES = bcs_pkg::TICK_CYCLES,
    parameter int unsigned MS_PER_MIN  = bcs_pkg::MS_PER_MIN
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Register port
    input  wire logic [3:0]        addr_i,
    input  wire logic [15:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [15:0]       rdata_o,
    // Analog comparators, asynchronous to clk_i
    input  wire bcs_pkg::bcs_sense_t sense_i,
    // Power stage
    output bcs_pkg::bcs_drive_t    drive_o,
    // Pins
    output logic                   irq_n_o,
    output logic                   charging_indicator_n_o,
    output logic                   charging_indicator_oe_o
);

    localparam int unsigned SW = $bits(bcs_pkg::bcs_sense_t);

    typedef struct packed {
        logic [SW-1:0]       sync1;
        logic [SW-1:0]       sync2;
        logic                valid_d;
        bcs_pkg::bcs_state_t state;
        logic [8:0]          ctrl;
        logic                hold_d;
        logic                in_flag;
        logic                chg_flag;
        logic [31:0]         tick_cnt;
        logic                tick;
        logic                half;
        logic [31:0]         pre_ms;
        logic [31:0]         tot_ms;
        logic [5:0]          relax;
        logic                relax_on;
        logic [15:0]         rdata;
        bcs_pkg::bcs_drive_t drive;
        logic                irq_n;
        logic                ind_oe;
    } bcs_regs_t;

    bcs_regs_t r_reg;
    bcs_regs_t r_next;

    // Period in ms for a select code; zero means the timer is disabled
    function automatic logic [31:0] limit_ms(input logic [1:0] sel, input logic total);
        logic [31:0] mins;
        mins = 32'd0;
        unique case (sel)
            2'h0: mins = total ? 32'(bcs_pkg::TOT_MIN_0) : 32'(bcs_pkg::PRE_MIN_0);
            2'h1: mins = total ? 32'(bcs_pkg::TOT_MIN_1) : 32'(bcs_pkg::PRE_MIN_1);
            2'h2: mins = total ? 32'(bcs_pkg::TOT_MIN_2) : 32'(bcs_pkg::PRE_MIN_2);
            2'h3: mins = 32'd0;
        endcase
        return 32'(mins * MS_PER_MIN);
    endfunction : limit_ms

    // State code readout
    function automatic logic [1:0] state_code(input bcs_pkg::bcs_state_t s);
        logic [1:0] c;
        c = bcs_pkg::CODE_IDLE;
        unique case (s)
            bcs_pkg::BCS_PRECOND: c = bcs_pkg::CODE_PRE;
            bcs_pkg::BCS_FAST,
            bcs_pkg::BCS_TOPOFF:  c = bcs_pkg::CODE_FAST;
            bcs_pkg::BCS_EOC:     c = bcs_pkg::CODE_EOC;
            default:              c = bcs_pkg::CODE_IDLE;
        endcase
        return c;
    endfunction : state_code

    bcs_pkg::bcs_sense_t s;
    assign s = bcs_pkg::bcs_sense_t'(r_reg.sync2);

    // Next-state logic for the whole block
    always_comb begin
        logic        pre_exp;
        logic        tot_exp;
        logic        fault_cond;
        logic        conn_ev;
        logic        disc_ev;
        logic        in_eoc;
        logic        was_eoc;
        logic        rd_st;
        logic [15:0] st;
        pre_exp    = 1'b0;
        tot_exp    = 1'b0;
        fault_cond = 1'b0;
        conn_ev    = 1'b0;
        disc_ev    = 1'b0;
        in_eoc     = 1'b0;
        was_eoc    = 1'b0;
        rd_st      = 1'b0;
        st         = 16'h0000;
        r_next     = r_reg;

        // Two-flop synchroniser on every comparator input
        r_next.sync1 = sense_i;
        r_next.sync2 = r_reg.sync1;
        r_next.valid_d = s.input_valid;
        r_next.hold_d  = r_reg.ctrl[bcs_pkg::CTRL_HOLD];

        // Millisecond tick
        r_next.tick = 1'b0;
        if (r_reg.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            r_next.tick_cnt = 32'h0;
            r_next.tick     = 1'b1;
        end else begin
            r_next.tick_cnt = r_reg.tick_cnt + 32'h1;
        end

        // Safety timers run at half rate while current is reduced, stretching the period
        pre_exp = (r_reg.ctrl[bcs_pkg::CTRL_PRE_LSB +: 2] != bcs_pkg::TIMER_OFF)
                  && (r_reg.pre_ms >= limit_ms(r_reg.ctrl[bcs_pkg::CTRL_PRE_LSB +: 2], 1'b0));
        tot_exp = (r_reg.ctrl[bcs_pkg::CTRL_TOT_LSB +: 2] != bcs_pkg::TIMER_OFF)
                  && (r_reg.tot_ms >= limit_ms(r_reg.ctrl[bcs_pkg::CTRL_TOT_LSB +: 2], 1'b1));
        // The tick counter is always zero beside a tick, so a separate toggle picks skipped ticks
        if (r_reg.tick && s.current_reduced)
            r_next.half = !r_reg.half;
        if (r_reg.tick && !(s.current_reduced && r_reg.half)) begin
            if (r_reg.state == bcs_pkg::BCS_PRECOND)
                r_next.pre_ms = r_reg.pre_ms + 32'h1;
            if (r_reg.state == bcs_pkg::BCS_PRECOND || r_reg.state == bcs_pkg::BCS_FAST
                || r_reg.state == bcs_pkg::BCS_TOPOFF)
                r_next.tot_ms = r_reg.tot_ms + 32'h1;
        end
        if (r_reg.relax_on && r_reg.tick)
            r_next.relax = r_reg.relax + 6'h1;

        // Charge-state machine
        fault_cond = !s.battery_present || !s.input_valid
                     || r_reg.ctrl[bcs_pkg::CTRL_HOLD];
        if (fault_cond) begin
            r_next.state = bcs_pkg::BCS_SUSPEND;
        end else begin
            unique case (r_reg.state)
                bcs_pkg::BCS_SUSPEND:
                    r_next.state = bcs_pkg::BCS_PRECOND;
                bcs_pkg::BCS_PRECOND:
                    if (s.above_precond)
                        r_next.state = bcs_pkg::BCS_FAST;
                    else if (pre_exp)
                        r_next.state = bcs_pkg::BCS_FAULT;
                bcs_pkg::BCS_FAST:
                    if (s.at_termination)
                        r_next.state = bcs_pkg::BCS_TOPOFF;
                    else if (tot_exp) begin
                        r_next.state    = bcs_pkg::BCS_EOC;
                        r_next.relax_on = 1'b1;
                        r_next.relax    = 6'h0;
                    end
                bcs_pkg::BCS_TOPOFF:
                    if (s.current_at_eoc || tot_exp)
                        r_next.state = bcs_pkg::BCS_EOC;
                bcs_pkg::BCS_EOC:
                    if ((r_reg.relax_on && r_reg.relax >= 6'(bcs_pkg::RELAX_TICKS))
                        || (!r_reg.relax_on && s.below_recharge)) begin
                        r_next.state    = bcs_pkg::BCS_PRECOND;
                        r_next.relax_on = 1'b0;
                    end
                bcs_pkg::BCS_FAULT:
                    r_next.state = bcs_pkg::BCS_FAULT;
            endcase
        end
        // A new cycle restarts both safety timers
        if (r_next.state == bcs_pkg::BCS_PRECOND && r_reg.state != bcs_pkg::BCS_PRECOND) begin
            r_next.pre_ms = 32'h0;
            r_next.tot_ms = 32'h0;
        end
        if (r_next.state != bcs_pkg::BCS_EOC)
            r_next.relax_on = 1'b0;

        // Events
        conn_ev = s.input_valid && !r_reg.valid_d;
        disc_ev = !s.input_valid && r_reg.valid_d;
        in_eoc  = r_next.state == bcs_pkg::BCS_EOC;
        was_eoc = r_reg.state == bcs_pkg::BCS_EOC;

        // Register port: writes to control, reads of status clear flags
        rd_st = rd_i && addr_i == bcs_pkg::ADDR_STATUS;
        if (wr_i && addr_i == bcs_pkg::ADDR_CTRL)
            r_next.ctrl = wdata_i[8:0];
        if (rd_st) begin
            r_next.in_flag  = 1'b0;
            r_next.chg_flag = 1'b0;
        end
        // Set wins over the clearing read
        if ((conn_ev && r_reg.ctrl[bcs_pkg::CTRL_IN_CON])
            || (disc_ev && r_reg.ctrl[bcs_pkg::CTRL_IN_DIS]))
            r_next.in_flag = 1'b1;
        if ((in_eoc && !was_eoc && r_reg.ctrl[bcs_pkg::CTRL_EOC_IN])
            || (!in_eoc && was_eoc && r_reg.ctrl[bcs_pkg::CTRL_EOC_OUT]))
            r_next.chg_flag = 1'b1;

        st[bcs_pkg::ST_IN_FLAG]  = r_reg.in_flag;
        st[bcs_pkg::ST_IN_VALID] = s.input_valid;
        st[bcs_pkg::ST_AC_SEL]   = s.ac_select_input;
        st[bcs_pkg::ST_CHG_FLAG] = r_reg.chg_flag;
        st[bcs_pkg::ST_EOC]      = was_eoc;
        st[bcs_pkg::ST_CODE_LSB +: 2] = state_code(r_reg.state);
        r_next.rdata = 16'h0000;
        if (rd_i && addr_i == bcs_pkg::ADDR_CTRL)
            r_next.rdata = {7'h00, r_reg.ctrl};
        else if (rd_st)
            r_next.rdata = st;

        // Current mode select
        r_next.drive.charge_en = r_next.state == bcs_pkg::BCS_PRECOND
                                 || r_next.state == bcs_pkg::BCS_FAST
                                 || r_next.state == bcs_pkg::BCS_TOPOFF;
        r_next.drive.cv_mode   = r_next.state == bcs_pkg::BCS_TOPOFF;
        r_next.drive.use_current_set_pin  = s.ac_select_input;
        if (s.ac_select_input) begin
            r_next.drive.input_limit_ma = 10'h000;
            r_next.drive.current_ma     = 10'h000;
            if (r_next.state == bcs_pkg::BCS_PRECOND)
                r_next.drive.current_set_pin_div = s.charge_level_input
                    ? 4'(bcs_pkg::PRE_DIV) : 4'(bcs_pkg::PRE_DIV);
            else
                r_next.drive.current_set_pin_div = s.charge_level_input
                    ? 4'h1 : 4'(bcs_pkg::AC_LOW_DIV);
        end else begin
            r_next.drive.current_set_pin_div = 4'h1;
            r_next.drive.input_limit_ma = s.charge_level_input
                ? bcs_pkg::USB_IN_HI_MA : bcs_pkg::USB_IN_LO_MA;
            if (r_next.state == bcs_pkg::BCS_PRECOND)
                r_next.drive.current_ma = bcs_pkg::USB_PRE_MA;
            else
                r_next.drive.current_ma = s.charge_level_input
                    ? bcs_pkg::USB_HI_MA : bcs_pkg::USB_LO_MA;
        end

        r_next.irq_n  = !(r_next.in_flag || r_next.chg_flag);
        r_next.ind_oe = r_next.drive.charge_en;
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg          <= '0;
            r_reg.state    <= bcs_pkg::BCS_SUSPEND;
            r_reg.ctrl     <= bcs_pkg::CTRL_RESET;
            r_reg.irq_n    <= 1'b1;
            r_reg.drive.current_set_pin_div <= 4'h1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rdata_o                 = r_reg.rdata;
    assign drive_o                 = r_reg.drive;
    assign irq_n_o                 = r_reg.irq_n;
    assign charging_indicator_n_o  = 1'b0; // Open drain: only sinks
    assign charging_indicator_oe_o = r_reg.ind_oe;

    // Assertions
    a_fault_is_suspend: assert property (@(posedge clk_i) disable iff (rst_i)
        (!s.battery_present || !s.input_valid) |=> r_reg.state == bcs_pkg::BCS_SUSPEND)
        else $error("suspend not entered on bad input or battery");
    a_irq_tracks_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        (r_reg.in_flag || r_reg.chg_flag) |-> !irq_n_o)
        else $error("irq line high while a flag is pending");
    a_read_clears_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_i && addr_i == bcs_pkg::ADDR_STATUS && !r_next.in_flag) |=> !r_reg.in_flag)
        else $error("input flag not cleared by read");
    a_read_returns_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_i && addr_i == bcs_pkg::ADDR_STATUS) |=>
        rdata_o[bcs_pkg::ST_CHG_FLAG] == $past(r_reg.chg_flag))
        else $error("charger flag readout wrong");
    a_indicator_active: assert property (@(posedge clk_i) disable iff (rst_i)
        r_reg.state == bcs_pkg::BCS_EOC |-> !charging_indicator_oe_o)
        else $error("indicator driven in end-of-charge");
    a_precond_to_fast: assert property (@(posedge clk_i) disable iff (rst_i)
        (r_reg.state == bcs_pkg::BCS_PRECOND && s.above_precond && s.battery_present
         && s.input_valid && !r_reg.ctrl[bcs_pkg::CTRL_HOLD]) |=> r_reg.state == bcs_pkg::BCS_FAST)
        else $error("precondition did not advance");
    a_eoc_set_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (r_next.state == bcs_pkg::BCS_EOC && r_reg.state != bcs_pkg::BCS_EOC
         && r_reg.ctrl[bcs_pkg::CTRL_EOC_IN]) |=> r_reg.chg_flag && !irq_n_o)
        else $error("eoc entry flag not raised");
    a_usb_low_limit: assert property (@(posedge clk_i) disable iff (rst_i)
        (!s.ac_select_input && !s.charge_level_input) |=>
        drive_o.input_limit_ma == bcs_pkg::USB_IN_LO_MA)
        else $error("usb low input limit wrong");

endmodule : bcs_charge_ctrl

`default_nettype wire

// *** tb/bcs_power_model.sv ***
// Behavioural power stage and battery that answer the charger's commands
`timescale 1ns/100ps
`default_nettype none
module bcs_power_model #(
    parameter int PRE_MV     = 3000,
    parameter int EOC_CYCLES = 20
) (
    // Clock
    input  wire logic                clk_i,
    // Commands from the charger
    input  wire bcs_pkg::bcs_drive_t drive_i,
    // Bench knobs
    input  wire logic                plug_i,
    input  wire logic                bat_i,
    input  wire logic                ac_i,
    input  wire logic                lvl_i,
    input  wire logic                reduce_i,
    input  wire logic signed [15:0]  rate_i,
    // Comparator levels
    output bcs_pkg::bcs_sense_t      sense_o
);
    int v_mv   = 2800;
    int cv_cnt = 0;

    // Cell gains charge only in constant current; a negative rate is a load that always drains
    always @(posedge clk_i) begin
        if (rate_i < 0) begin
            v_mv <= v_mv + rate_i;
        end else if (drive_i.charge_en && !drive_i.cv_mode && v_mv < 4200) begin
            v_mv <= v_mv + rate_i;
        end
        cv_cnt <= (drive_i.charge_en && drive_i.cv_mode) ? cv_cnt + 1 : 0;
    end

    // Comparator outputs, thresholds in millivolts
    always_comb begin
        sense_o.ac_select_input    = ac_i;
        sense_o.charge_level_input = lvl_i;
        sense_o.input_valid        = plug_i;
        sense_o.battery_present    = bat_i;
        sense_o.above_precond      = v_mv > PRE_MV;
        sense_o.at_termination     = v_mv >= 4200;
        sense_o.below_recharge     = v_mv <= 4200 - 205;
        sense_o.current_at_eoc     = cv_cnt >= EOC_CYCLES;
        sense_o.current_reduced    = reduce_i;
    end
endmodule : bcs_power_model
`default_nettype wire

// *** tb/test_battery_charge_state_control.sv ***
// Self-checking bench for the charge-state control block
`timescale 1ns/100ps
`default_nettype none
module test_battery_charge_state_control;
    localparam int TC        = 2;
    localparam int MPM       = 3;
    localparam int PRE_CYC   = bcs_pkg::PRE_MIN_0 * MPM * TC;
    localparam int TOT_CYC   = bcs_pkg::TOT_MIN_0 * MPM * TC;
    localparam int RELAX_CYC = bcs_pkg::RELAX_TICKS * TC;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    bcs_pkg::bcs_sense_t sense_i;
    bcs_pkg::bcs_drive_t drive_o;
    logic irq_n_o;
    logic charging_indicator_n_o;
    logic charging_indicator_oe_o;
    logic plug = 1'b0;
    logic bat = 1'b1;
    logic ac = 1'b0;
    logic lvl = 1'b1;
    logic reduce = 1'b0;
    logic signed [15:0] rate = 16'sh0;
    // Reference model of the flags, state code and control word
    logic m_in = 1'b0;
    logic m_chg = 1'b0;
    logic m_valid = 1'b0;
    logic [1:0] m_code = bcs_pkg::CODE_IDLE;
    logic [15:0] m_ctrl = 16'h0;
    int n_errors = 0;
    int n_compared = 0;

    always #10 clk_i = ~clk_i;

    bcs_charge_ctrl #(.TICK_CYCLES(TC), .MS_PER_MIN(MPM)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .sense_i(sense_i), .drive_o(drive_o),
        .irq_n_o(irq_n_o), .charging_indicator_n_o(charging_indicator_n_o),
        .charging_indicator_oe_o(charging_indicator_oe_o));

    bcs_power_model i_pm (
        .clk_i(clk_i), .drive_i(drive_o), .plug_i(plug), .bat_i(bat), .ac_i(ac),
        .lvl_i(lvl), .reduce_i(reduce), .rate_i(rate), .sense_o(sense_i));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    // One bus cycle; read data is taken in the single cycle where it stands
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= !w;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1 q = rdata_o;
    endtask : bus

    task automatic rd_status();
        logic [15:0] q;
        chk(16'(irq_n_o), 16'(!(m_in | m_chg)));
        bus(1'b0, bcs_pkg::ADDR_STATUS, 16'h0, q);
        chk(q, 16'({m_code, m_code == bcs_pkg::CODE_EOC, m_chg, ac, m_valid, m_in}));
        m_in = 1'b0; // Both flags clear on the read
        m_chg = 1'b0;
    endtask : rd_status

    // All four interrupt enables stay on so every event is seen
    task automatic wr_ctrl(input logic h, input logic [1:0] p, input logic [1:0] t);
        logic [15:0] q;
        m_ctrl = 16'(h) | (16'hf << bcs_pkg::CTRL_IN_CON) | (16'(p) << bcs_pkg::CTRL_PRE_LSB)
                 | (16'(t) << bcs_pkg::CTRL_TOT_LSB);
        bus(1'b1, bcs_pkg::ADDR_CTRL, m_ctrl, q);
        bus(1'b0, bcs_pkg::ADDR_CTRL, 16'h0, q);
        chk(q, m_ctrl);
    endtask : wr_ctrl

    task automatic restart(input logic [1:0] p, input logic [1:0] t);
        wr_ctrl(1'b1, p, t);
        settle(6);
        chk(16'(charging_indicator_oe_o), 16'h0);
        wr_ctrl(1'b0, p, t);
        settle(6);
        chk(16'(charging_indicator_oe_o), 16'h1);
    endtask : restart

    function automatic logic probe(input int w);
        case (w)
            0: return charging_indicator_oe_o;
            1: return drive_o.cv_mode;
            default: return drive_o.current_ma == bcs_pkg::USB_HI_MA;
        endcase
    endfunction : probe

    // Bounded wait for a level, then one comparison of it
    task automatic wait_for(input int w, input logic val, input int lim);
        for (int i = 0; i < lim && probe(w) !== val; i++) settle(1);
        chk(16'(probe(w)), 16'(val));
    endtask : wait_for

    task automatic stay(input int w, input logic val, input int n);
        logic ok = 1'b1;
        repeat (n) begin
            settle(1);
            if (probe(w) !== val) ok = 1'b0;
        end
        chk(16'(ok), 16'h1);
    endtask : stay

    task automatic chk_mode(input logic pre);
        if (ac) begin
            chk(16'(drive_o.use_current_set_pin), 16'h1);
            chk(16'(drive_o.current_set_pin_div), pre ? 16'(bcs_pkg::PRE_DIV)
                : lvl ? 16'h1 : 16'(bcs_pkg::AC_LOW_DIV));
        end else begin
            chk(16'(drive_o.current_ma), pre ? 16'(bcs_pkg::USB_PRE_MA)
                : lvl ? 16'(bcs_pkg::USB_HI_MA) : 16'(bcs_pkg::USB_LO_MA));
            if (!pre) chk(16'(drive_o.input_limit_ma), lvl ? 16'(bcs_pkg::USB_IN_HI_MA)
                : 16'(bcs_pkg::USB_IN_LO_MA));
        end
    endtask : chk_mode

    // Hang guard, sized well above the longest timer scenario
    initial begin
        #200_000;
        n_errors++;
        print_verdict();
    end

    initial begin
        logic [15:0] q;
        void'($urandom(74));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(2);
        chk(16'(irq_n_o), 16'h1);
        chk(16'(charging_indicator_n_o), 16'h0);
        rd_status();
        bus(1'b1, 4'(2 + $urandom % 14), 16'hffff, q);
        bus(1'b0, 4'(2 + $urandom % 14), 16'h0, q);
        chk(q, 16'h0);
        bus(1'b0, bcs_pkg::ADDR_CTRL, 16'h0, q);
        chk(q, 16'(bcs_pkg::CTRL_RESET));
        wr_ctrl(1'b0, 2'h0, 2'h0);
        // Supply connect, disconnect, reconnect, then battery removal
        for (int k = 0; k < 3; k++) begin
            plug <= (k != 1);
            settle(8);
            {m_in, m_valid} = {1'b1, k != 1};
            m_code = (k != 1) ? bcs_pkg::CODE_PRE : bcs_pkg::CODE_IDLE;
            chk(16'(charging_indicator_oe_o), 16'(k != 1));
            rd_status();
        end
        rd_status();
        bat <= 1'b0;
        settle(8);
        m_code = bcs_pkg::CODE_IDLE;
        rd_status();
        bat <= 1'b1;
        settle(8);
        m_code = bcs_pkg::CODE_PRE;
        rd_status();
        for (int k = 0; k < 4; k++) begin
            {ac, lvl} <= 2'(k);
            settle(6);
            chk_mode(1'b1);
            rd_status();
        end
        // Precondition timer expiry, sticky fault, stretch, disabled timer
        restart(2'h0, 2'h0);
        stay(0, 1'b1, PRE_CYC - 40);
        wait_for(0, 1'b0, 80);
        m_code = bcs_pkg::CODE_IDLE;
        rd_status();
        stay(0, 1'b0, 50);
        reduce <= 1'b1;
        restart(2'h0, 2'h0);
        stay(0, 1'b1, 2 * PRE_CYC - 40);
        wait_for(0, 1'b0, 120);
        reduce <= 1'b0;
        restart(2'h3, 2'h0);
        stay(0, 1'b1, 600);
        // Full charge: fast-charge, top-off, end-of-charge, recharge
        {ac, lvl} <= 2'h1;
        restart(2'h0, 2'h0);
        rate <= 16'(5 + $urandom % 16);
        wait_for(2, 1'b1, 100);
        rate <= 16'sh0;
        m_code = bcs_pkg::CODE_FAST;
        settle(4);
        rd_status();
        for (int k = 0; k < 4; k++) begin
            {ac, lvl} <= 2'(k);
            settle(6);
            chk_mode(1'b0);
        end
        {ac, lvl} <= 2'h1;
        rate <= 16'(5 + $urandom % 16);
        wait_for(1, 1'b1, 300);
        rd_status();
        wait_for(0, 1'b0, 100);
        {m_code, m_chg} = {bcs_pkg::CODE_EOC, 1'b1};
        settle(2);
        rd_status();
        chk(16'(drive_o.charge_en), 16'h0);
        // A gentle drain keeps the cell above the precondition level, so it goes on to fast-charge
        rate <= -16'sd60;
        wait_for(0, 1'b1, 50);
        rate <= 16'sh0;
        {m_code, m_chg} = {bcs_pkg::CODE_FAST, 1'b1};
        settle(4);
        rd_status();
        // Total timer expiry in fast-charge, then restart after the relax time
        restart(2'h0, 2'h0);
        rate <= 16'sd20;
        wait_for(2, 1'b1, 100);
        rate <= 16'sh0;
        stay(0, 1'b1, TOT_CYC - 150);
        wait_for(0, 1'b0, 300);
        {m_code, m_chg} = {bcs_pkg::CODE_EOC, 1'b1};
        settle(2);
        rd_status();
        stay(0, 1'b0, RELAX_CYC - 14);
        wait_for(0, 1'b1, 40);
        print_verdict();
    end
endmodule : test_battery_charge_state_control
`default_nettype wire
